// [design/twmr_core.sv]
// two-wire master receiver: register port, byte engine, bus pins
// assumes open-drain bus pins resolved outside, slave on the far side
//
// Operation
// - start only after the bus is free
// - writing one to flag clears it, resumes
// - start sent: flag set, status 0x08
// - address direction bit picks transmit or receive
// - status low three bits read as zero
// - after read address: 0x38, 0x40 or 0x48
// - received byte held readable while flag set
// - stop request sends stop, clears stop bit
// - repeated start reported as 0x10
// - after 0x10 write address means transmit
// - lost arbitration: release, or retry start
// - next byte acked per ack enable bit
// - after 0x48: restart, stop, or both
// - byte received with ack gives 0x50
// - byte received with nack gives 0x58
// - data write with flag low sets collision
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module twmr_core #(
    parameter int HALF = twmr_pkg::SCL_HALF_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input twmr_pkg::twmr_req_t i_req,
    output logic [7:0] o_rdata,
    input wire logic i_scl,
    output logic o_scl_o,
    output logic o_scl_oe,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic o_irq
);
    import twmr_pkg::*;

    localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

    logic [7:0] ctl, stat, data, shift, cnt, next_code;
    logic [3:0] bitc;
    logic [1:0][SYNC_LEN-1:0] sync;
    logic [1:0] pin_raw, pin_f, pin_fp;
    logic flag, wcol, busy, scl_low, sda_low, rs, addr_ph;
    logic rx_mode, ack_sel, en, scl_f, sda_f, wr_ctl, wr_dat;
    logic half_done, txing, drive_bit, bit_end, lost_ev;
    logic byte_end, start_end, set_ev, clr_ev, stop_done;
    twmr_state_t state;

    // ------------------------------------------------------------
    // pin synchronisers and bus state
    // ------------------------------------------------------------
    assign pin_raw = {i_scl, i_sda};
    assign scl_f = pin_f[1];
    assign sda_f = pin_f[0];

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            sync <= '1;
            pin_f <= '1;
            pin_fp <= '1;
        end else begin
            pin_fp <= pin_f;
            for (int i = 0; i < 2; i++) begin
                sync[i] <= {sync[i][SYNC_LEN-2:0], pin_raw[i]};
                if (sync[i][1] == sync[i][2]) begin
                    pin_f[i] <= sync[i][2];
                end
            end
        end
    end

    // start and stop seen on the wires
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            busy <= 1'b0;
        end else if (scl_f && pin_fp[1] && pin_fp[0] && !sda_f) begin
            busy <= 1'b1;
        end else if (scl_f && pin_fp[1] && !pin_fp[0] && sda_f) begin
            busy <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // event terms
    // ------------------------------------------------------------
    assign en = ctl[B_EN];
    assign wr_ctl = i_req.wr && (i_req.addr == ADR_CTL);
    assign wr_dat = i_req.wr && (i_req.addr == ADR_DATA);
    assign clr_ev = wr_ctl && i_req.wdata[B_FLAG];
    assign half_done = (cnt == HALF_M1);
    assign txing = addr_ph || !rx_mode;
    assign drive_bit = (bitc < ACK_BIT) ? txing : !txing;
    assign bit_end = (state == ST_BIT_HI) && scl_f && half_done;
    assign lost_ev = bit_end && drive_bit && !sda_low && !sda_f;
    assign byte_end = bit_end && !lost_ev && (bitc == ACK_BIT);
    assign start_end = (state == ST_START_H) && half_done;
    assign stop_done = (state == ST_STOP_END) && half_done;
    assign set_ev = start_end || byte_end || lost_ev;

    always_comb begin
        next_code = SC_NONE;
        if (lost_ev) begin
            next_code = SC_LOST;
        end else if (start_end) begin
            next_code = rs ? SC_RSTART : SC_START;
        end else if (addr_ph && rx_mode) begin
            next_code = !sda_f ? SC_RA_ACK : SC_RA_NACK;
        end else if (addr_ph) begin
            next_code = !sda_f ? SC_WA_ACK : SC_WA_NACK;
        end else if (rx_mode) begin
            next_code = ack_sel ? SC_RD_ACK : SC_RD_NACK;
        end else begin
            next_code = !sda_f ? SC_WD_ACK : SC_WD_NACK;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            flag <= 1'b0;
        end else if (set_ev) begin
            flag <= 1'b1;
        end else if (clr_ev) begin
            flag <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            stat <= SC_NONE;
        end else if (set_ev) begin
            stat <= next_code & STAT_MASK;
        end else if (clr_ev) begin
            stat <= SC_NONE;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            ctl <= CTL_RST;
        end else if (wr_ctl) begin
            ctl <= i_req.wdata & CTL_WMASK;
        end else if (stop_done) begin
            ctl[B_STO] <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            wcol <= 1'b0;
        end else if (wr_dat && !flag) begin
            wcol <= 1'b1;
        end else if (clr_ev) begin
            wcol <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            data <= DATA_RST;
        end else if (wr_dat && flag) begin
            data <= i_req.wdata;
        end else if (byte_end && rx_mode && !addr_ph) begin
            data <= shift;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= flag && ctl[B_IE];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_rdata <= '0;
        end else if (i_req.rd && i_req.addr == ADR_CTL) begin
            o_rdata <= {flag, ctl[B_ACK:B_STO], wcol, ctl[B_EN], 1'b0,
                        ctl[B_IE]};
        end else if (i_req.rd && i_req.addr == ADR_STAT) begin
            o_rdata <= stat;
        end else if (i_req.rd && i_req.addr == ADR_DATA) begin
            o_rdata <= data;
        end else begin
            o_rdata <= '0;
        end
    end

    // ------------------------------------------------------------
    // bus sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || !en) begin
            state <= ST_IDLE;
            cnt <= '0;
            bitc <= '0;
            shift <= '0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            rs <= 1'b0;
            addr_ph <= 1'b0;
            rx_mode <= 1'b0;
            ack_sel <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    cnt <= '0;
                    if (ctl[B_STA] && !flag) begin
                        state <= ST_WAIT_FREE;
                    end
                end
                ST_WAIT_FREE: begin
                    if (!busy) begin
                        sda_low <= 1'b1;
                        rs <= 1'b0;
                        cnt <= '0;
                        state <= ST_START_H;
                    end
                end
                ST_START_H: begin
                    if (half_done) begin
                        scl_low <= 1'b1;
                        addr_ph <= 1'b1;
                        cnt <= '0;
                        state <= ST_HOLD;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                ST_HOLD: begin
                    scl_low <= 1'b1;
                    cnt <= '0;
                    if (!flag && ctl[B_STO]) begin
                        sda_low <= 1'b1;
                        state <= ST_STOP_LO;
                    end else if (!flag && ctl[B_STA]) begin
                        sda_low <= 1'b0;
                        state <= ST_RS_LO;
                    end else if (!flag) begin
                        bitc <= '0;
                        ack_sel <= ctl[B_ACK];
                        shift <= data;
                        if (addr_ph) begin
                            rx_mode <= data[0];
                        end
                        state <= ST_BIT_LO;
                    end
                end
                ST_BIT_LO: begin
                    if (cnt == '0 && bitc < ACK_BIT) begin
                        sda_low <= txing && !shift[7];
                    end else if (cnt == '0) begin
                        sda_low <= !txing && ack_sel;
                    end
                    if (half_done) begin
                        scl_low <= 1'b0;
                        cnt <= '0;
                        state <= ST_BIT_HI;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                ST_BIT_HI: begin
                    if (!scl_f) begin
                        cnt <= '0;
                    end else if (lost_ev) begin
                        sda_low <= 1'b0;
                        cnt <= '0;
                        state <= ST_LOST;
                    end else if (half_done && bitc < ACK_BIT) begin
                        shift <= {shift[6:0], sda_f};
                        bitc <= bitc + 4'h1;
                        scl_low <= 1'b1;
                        cnt <= '0;
                        state <= ST_BIT_LO;
                    end else if (half_done) begin
                        scl_low <= 1'b1;
                        addr_ph <= 1'b0;
                        cnt <= '0;
                        state <= ST_HOLD;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                ST_LOST: begin
                    scl_low <= 1'b0;
                    sda_low <= 1'b0;
                    if (!flag) begin
                        state <= ctl[B_STA] ? ST_WAIT_FREE : ST_IDLE;
                    end
                end
                ST_STOP_LO: begin
                    if (half_done) begin
                        scl_low <= 1'b0;
                        cnt <= '0;
                        state <= ST_STOP_HI;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                ST_STOP_HI: begin
                    if (!scl_f) begin
                        cnt <= '0;
                    end else if (half_done) begin
                        sda_low <= 1'b0;
                        cnt <= '0;
                        state <= ST_STOP_END;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                ST_STOP_END: begin
                    if (half_done) begin
                        cnt <= '0;
                        state <= ctl[B_STA] ? ST_WAIT_FREE : ST_IDLE;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                ST_RS_LO: begin
                    if (half_done) begin
                        scl_low <= 1'b0;
                        cnt <= '0;
                        state <= ST_RS_HI;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                ST_RS_HI: begin
                    if (!scl_f) begin
                        cnt <= '0;
                    end else if (half_done) begin
                        sda_low <= 1'b1;
                        rs <= 1'b1;
                        cnt <= '0;
                        state <= ST_START_H;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    assign o_scl_o = 1'b0;
    assign o_sda_o = 1'b0;
    assign o_scl_oe = scl_low;
    assign o_sda_oe = sda_low;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    start_free_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (state == ST_WAIT_FREE && busy && en) |=> !o_sda_oe)
        else $error("start issued on a busy bus");
    flag_clear_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (clr_ev && !set_ev) |=> !flag)
        else $error("flag not cleared by write of one");
    start_code_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (start_end && !rs && en) |=> (flag && stat == SC_START))
        else $error("start not reported as 0x08");
    mode_pick_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (state == ST_BIT_LO && bitc == '0 && cnt == '0 && addr_ph)
        |-> (rx_mode == data[0]))
        else $error("mode differs from address direction");
    stat_mask_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (stat & ~STAT_MASK) == '0)
        else $error("status low bits not zero");
    addr_code_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (byte_end && addr_ph && rx_mode && en)
        |=> flag && (stat == SC_RA_ACK || stat == SC_RA_NACK))
        else $error("bad status after read address");
    rx_byte_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (byte_end && !addr_ph && rx_mode)
        |=> (data == $past(shift)) && flag)
        else $error("received byte not in data register");
    ack_drive_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (state == ST_BIT_HI && bitc == ACK_BIT && !txing)
        |-> (o_sda_oe == ack_sel))
        else $error("ack bit differs from ack enable");
    stop_clear_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (stop_done && !wr_ctl && en) |=> !ctl[B_STO] && !o_sda_oe)
        else $error("stop request bit not cleared");
    rs_code_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (start_end && rs && en) |=> (stat == SC_RSTART))
        else $error("repeated start not reported as 0x10");
    lost_free_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        lost_ev |=> !o_sda_oe && stat == SC_LOST ##1 !o_scl_oe)
        else $error("bus not released after lost arbitration");
    wcol_set_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (wr_dat && !flag && !byte_end) |=> wcol && $stable(data))
        else $error("collision write not discarded");
    hold_low_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (state == ST_HOLD && flag) |-> o_scl_oe)
        else $error("clock released while flag set");
    irq_req_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (flag && ctl[B_IE]) |=> o_irq)
        else $error("interrupt request missing");
endmodule

// [design/twmr_pkg.sv]
// constants and types of the two-wire master receiver
// assumes a 10 MHz core clock and a bus clock of 800 ns period
package twmr_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int SCL_HALF_NS = 400;
    localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_LEN = 3;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [1:0] ADR_CTL = 2'h0;
    localparam logic [1:0] ADR_STAT = 2'h1;
    localparam logic [1:0] ADR_DATA = 2'h2;
    localparam int B_FLAG = 7;
    localparam int B_ACK = 6;
    localparam int B_STA = 5;
    localparam int B_STO = 4;
    localparam int B_WCOL = 3;
    localparam int B_EN = 2;
    localparam int B_IE = 0;
    localparam logic [7:0] CTL_WMASK = 8'h75;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'hFF;
    localparam logic [7:0] STAT_MASK = 8'hF8;
    localparam logic [3:0] ACK_BIT = 4'h8;
    // ------------------------------------------------------------
    // status codes
    // ------------------------------------------------------------
    localparam logic [7:0] SC_START = 8'h08;
    localparam logic [7:0] SC_RSTART = 8'h10;
    localparam logic [7:0] SC_WA_ACK = 8'h18;
    localparam logic [7:0] SC_WA_NACK = 8'h20;
    localparam logic [7:0] SC_WD_ACK = 8'h28;
    localparam logic [7:0] SC_WD_NACK = 8'h30;
    localparam logic [7:0] SC_LOST = 8'h38;
    localparam logic [7:0] SC_RA_ACK = 8'h40;
    localparam logic [7:0] SC_RA_NACK = 8'h48;
    localparam logic [7:0] SC_RD_ACK = 8'h50;
    localparam logic [7:0] SC_RD_NACK = 8'h58;
    localparam logic [7:0] SC_NONE = 8'hF8;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } twmr_req_t;
    typedef enum logic [3:0] {
        ST_IDLE, ST_WAIT_FREE, ST_START_H, ST_HOLD, ST_BIT_LO,
        ST_BIT_HI, ST_LOST, ST_STOP_LO, ST_STOP_HI, ST_STOP_END,
        ST_RS_LO, ST_RS_HI
    } twmr_state_t;
endpackage

// [bench/twmr_slave.sv]
// behavioural slave transmitter on the two-wire bus
// assumes resolved wires with pull-ups: a released line reads high
`timescale 1ns/10ps
module twmr_slave #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [7:0] i_first,
    input wire logic i_slow,
    input wire logic i_grab,
    output logic o_scl_oe,
    output logic o_sda_oe
);
    // mode 0 idle, 1 address, 2 sending bytes
    logic [1:0] mode = 2'h0;
    logic [3:0] b = 4'h0;
    logic [7:0] sh = 8'h00;
    logic [7:0] data = 8'h00;
    logic mack = 1'b0;
    initial o_scl_oe = 1'b0;
    initial o_sda_oe = 1'b0;
    // ------------------------------------------------------------
    // start and stop on the wires
    // ------------------------------------------------------------
    always @(negedge i_sda) begin
        if (i_scl === 1'b1) begin
            mode = 2'h1;
            b = 4'hf;
            o_sda_oe = 1'b0;
        end
    end
    always @(posedge i_sda) begin
        if (i_scl === 1'b1) begin
            mode = 2'h0;
            o_sda_oe = 1'b0;
        end
    end
    // another master giving up the data line makes a stop
    always @(negedge i_grab) o_sda_oe = 1'b0;
    // ------------------------------------------------------------
    // bit engine
    // ------------------------------------------------------------
    always @(posedge i_scl) begin
        if (mode == 2'h1 && b < 4'h8) sh = {sh[6:0], i_sda};
        if (mode == 2'h2 && b == 4'h8) mack = !i_sda;
    end
    always @(negedge i_scl) begin
        if (b == 4'h8) begin
            b = 4'h0;
            if (mode == 2'h1) begin
                mode = (sh[7:1] == ADDR && sh[0]) ? 2'h2 : 2'h0;
                data = i_first;
            end else if (mode == 2'h2 && mack) begin
                data = data + 8'h01;
            end else begin
                mode = 2'h0;
            end
        end else begin
            b = b + 4'h1;
        end
        if (mode == 2'h1) begin
            o_sda_oe = (b == 4'h8) ? (sh[7:1] == ADDR) : i_grab;
        end else if (mode == 2'h2) begin
            o_sda_oe = (b == 4'h8) ? 1'b0 : !data[3'h7 - b[2:0]];
        end else begin
            o_sda_oe = 1'b0;
        end
        // a slow slave stretches each low phase
        if (i_slow) begin
            o_scl_oe = 1'b1;
            #1000;
            o_scl_oe = 1'b0;
        end
    end
endmodule

// [bench/test_twmr_core.sv]
// self-checking bench of the two-wire master receiver
// assumes the package, the core and the slave model are compiled first
`timescale 1ns/10ps
module test_twmr_core;
    import twmr_pkg::*;
    localparam logic [7:0] RADR = 8'h55;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    twmr_req_t req = '0;
    logic [7:0] rdata;
    logic m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe, irq;
    logic [7:0] first = 8'h00;
    logic slow = 1'b0;
    logic grab = 1'b0;
    int n_errors = 0;
    int cmp_count = 0;
    wire scl = !(m_scl_oe | s_scl_oe);
    wire sda = !(m_sda_oe | s_sda_oe);
    always #50 clk = ~clk;
    twmr_core twmr_core_inst (.i_ref_clk(clk), .i_rstn(rstn), .i_req(req),
        .o_rdata(rdata), .i_scl(scl), .o_scl_o(), .o_scl_oe(m_scl_oe),
        .i_sda(sda), .o_sda_o(), .o_sda_oe(m_sda_oe), .o_irq(irq));
    twmr_slave twmr_slave_inst (.i_scl(scl), .i_sda(sda), .i_first(first),
        .i_slow(slow), .i_grab(grab), .o_scl_oe(s_scl_oe),
        .o_sda_oe(s_sda_oe));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        #1 d = rdata;
    endtask
    task automatic expect_reg(input string what, input logic [1:0] a,
                              input logic [7:0] exp);
        logic [7:0] v;
        reg_rd(a, v);
        check(what, v, exp);
    endtask
    // poll a control bit until it reaches the level, bounded
    task automatic wait_bit(input int b, input logic lvl);
        logic [7:0] v;
        v = 8'h00;
        for (int k = 0; k < 1000; k++) begin
            reg_rd(ADR_CTL, v);
            if (v[b] === lvl) break;
        end
        check("control wait", {7'h00, v[b]}, {7'h00, lvl});
    endtask
    task automatic step(input logic [7:0] ctl, input logic [7:0] st);
        reg_wr(ADR_CTL, ctl);
        wait_bit(B_FLAG, 1'b1);
        expect_reg("status", ADR_STAT, st);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        expect_reg("control", ADR_CTL, CTL_RST);
        expect_reg("status", ADR_STAT, SC_NONE);
        expect_reg("data", ADR_DATA, DATA_RST);
        expect_reg("unmapped", 2'h3, 8'h00);
        reg_wr(ADR_STAT, 8'h00);
        expect_reg("status ro", ADR_STAT, SC_NONE);
        reg_wr(ADR_DATA, 8'h12);
        expect_reg("data kept", ADR_DATA, DATA_RST);
        expect_reg("collision", ADR_CTL, 8'h08);
        reg_wr(ADR_CTL, 8'h80);
        expect_reg("collision clear", ADR_CTL, 8'h00);
    endtask
    task automatic t_read(input int n, input logic s, input logic [7:0] f);
        first <= f;
        slow <= s;
        step(8'ha5, SC_START);
        check("irq", {7'h00, irq}, 8'h01);
        reg_wr(ADR_DATA, RADR);
        step(8'h85, SC_RA_ACK);
        check("scl held", {7'h00, m_scl_oe}, 8'h01);
        for (int i = 0; i < n; i++) begin
            step((i < n - 1) ? 8'hc5 : 8'h85,
                 (i < n - 1) ? SC_RD_ACK : SC_RD_NACK);
            expect_reg("byte", ADR_DATA, f + 8'(i));
        end
        reg_wr(ADR_CTL, 8'h95);
        wait_bit(B_STO, 1'b0);
        expect_reg("after stop", ADR_CTL, 8'h05);
        check("bus idle", {6'h00, scl, sda}, 8'h03);
    endtask
    task automatic t_nack_addr();
        first <= 8'h3c;
        step(8'ha4, SC_START);
        check("irq masked", {7'h00, irq}, 8'h00);
        reg_wr(ADR_DATA, 8'h65);
        step(8'h84, SC_RA_NACK);
        step(8'ha4, SC_RSTART);
        reg_wr(ADR_DATA, RADR);
        step(8'h84, SC_RA_ACK);
        step(8'h84, SC_RD_NACK);
        expect_reg("byte", ADR_DATA, 8'h3c);
        step(8'hb4, SC_START);
        expect_reg("stop cleared", ADR_CTL, 8'ha4);
        reg_wr(ADR_CTL, 8'h94);
        wait_bit(B_STO, 1'b0);
    endtask
    task automatic t_lost();
        grab <= 1'b1;
        step(8'ha4, SC_START);
        reg_wr(ADR_DATA, RADR);
        step(8'h84, SC_LOST);
        check("lines free", {6'h00, m_scl_oe, m_sda_oe}, 8'h00);
        reg_wr(ADR_CTL, 8'ha4);
        repeat (40) @(posedge clk);
        expect_reg("waits busy", ADR_CTL, 8'h24);
        grab <= 1'b0;
        wait_bit(B_FLAG, 1'b1);
        expect_reg("retry", ADR_STAT, SC_START);
        reg_wr(ADR_CTL, 8'h94);
        wait_bit(B_STO, 1'b0);
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_read(1, 1'b0, 8'ha7);
        t_read(3, 1'b1, 8'hfe);
        t_nack_addr();
        t_lost();
        finish_test();
    end
    initial begin
        #5_000_000;
        n_errors++;
        finish_test();
    end
endmodule
